// File: accessory_regs_defs.svh
// Constants for the latch, debug, scratch and accessory register slice.
// Assumes the includer sits in the ULPI clock domain and uses these names only.
`ifndef ACCESSORY_REGS_DEFS_SVH
`define ACCESSORY_REGS_DEFS_SVH
`define ADDR_EVENT_LATCH   6'h14
`define ADDR_LINE_STATE    6'h15
`define ADDR_SCRATCH       6'h16
`define ADDR_ACC_CTRL      6'h19
`define ADDR_ACC_IRQ_EN    6'h1d
`define RESET_BYTE         8'h00
`define LATCH_MASK         8'h1f
`define LINE_STATE_MASK    8'h03
`define IRQ_EN_WRITE_MASK  8'h67
`define CTRL_WRITE_MASK    8'hfe
`define BIT_ID_GND_DRIVE   1
`define BIT_TX_ROUTE       2
`define BIT_RX_ROUTE       3
`define BIT_LEFT_AUDIO     4
`define BIT_RIGHT_AUDIO    5
`define BIT_MIC            6
`define BIT_DATA2_TRISTATE 7
`define BIT_IRQ_FLOAT_BEG  0
`define BIT_IRQ_FLOAT_END  1
`define BIT_IRQ_VDAT       2
`define BIT_IRQ_RID        5
`define NUM_ASYNC          11
`endif

// File: accessory_regs_pkg.sv
// Types shared by the register slice.
// Assumes accessory_regs_defs.svh supplies the numeric constants.
package accessory_regs_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [5:0] reg_addr_t;
    typedef enum logic [1:0] {OP_WRITE, OP_SET, OP_CLEAR, OP_NONE} alias_op_t;
endpackage : accessory_regs_pkg

// File: ulpi_phy_latch_carkit_regs.sv
// Event latch, line-state debug, scratch and accessory control/interrupt registers.
// Assumes register accesses arrive already unpacked from the ULPI register
// protocol as one-cycle read/write strobes in the ULPI clock domain.
`timescale 1ns/10ps
`include "accessory_regs_defs.svh"
module ulpi_phy_latch_carkit_regs (
    input  wire logic                          clk,                 // ULPI clock, 125 MHz
    input  wire logic                          rst,                 // Sync reset, active high
    input  wire accessory_regs_pkg::reg_addr_t reg_addr,            // Register address
    input  wire accessory_regs_pkg::reg_byte_t reg_wdata,           // Write data
    input  wire logic                          reg_write,           // Write strobe, one cycle
    input  wire logic                          reg_read,            // Read strobe, one cycle
    output logic                               reg_rvalid,          // Read data valid, one cycle
    output accessory_regs_pkg::reg_byte_t      reg_rdata,           // Read data, registered
    input  wire logic [4:0]                    rise_enable,         // Rising enables, same clock
    input  wire logic [4:0]                    fall_enable,         // Falling enables, same clock
    input  wire logic                          host_role,           // Device acts as host
    input  wire logic                          accessory_mode_select, // Accessory mode bit
    input  wire logic                          vendor_rid_irq_enable, // Vendor copy of enable
    input  wire logic [4:0]                    utmi_status,         // Async: hd,vb,sv,se,idg
    input  wire logic [1:0]                    line_state,          // Async line state
    input  wire logic                          id_float,            // Async ID floating
    input  wire logic                          vdat_det,            // Async DP voltage detect
    input  wire logic                          id_resistor_conversion_complete, // Async
    input  wire logic                          dp_in,               // Async DP level (UART rx)
    input  wire logic                          data0_in,            // Data line 0 (UART tx)
    output logic                               data1_out,           // Data line 1 value
    output logic                               data1_oe,            // Data line 1 enable
    output logic                               data2_out,           // Data line 2 value
    output logic                               data2_oe,            // Data line 2 enable
    output logic                               dm_out,              // UART tx driven on DM
    output logic                               dm_oe,               // DM driver enable
    output logic                               uart_tx_to_dm,       // Switch: tx to DM
    output logic                               uart_rx_from_dp,     // Switch: DP to rx
    output logic                               left_speaker_pin,    // Switch: DM to left
    output logic                               right_speaker_pin,   // Switch: DP to right
    output logic                               left_speaker_data,   // UART data on left
    output logic                               right_speaker_data,  // UART data on right
    output logic                               se_receiver_disable, // Single-ended rx off
    output logic                               id_pin_ground_drive, // Ground the ID pin
    output logic                               alt_int,             // Alt interrupt for RXCMD
    input  wire logic                          alt_int_ack          // RXCMD carrying it sent
);
    import accessory_regs_pkg::*;

    // Apply a write, set or clear alias to a stored byte
    function automatic reg_byte_t alias_apply(input reg_byte_t cur, input reg_byte_t wd,
                                              input alias_op_t op);
        unique case (op)
            OP_WRITE: alias_apply = wd;
            OP_SET:   alias_apply = cur | wd;
            OP_CLEAR: alias_apply = cur & ~wd;
            OP_NONE:  alias_apply = cur;
        endcase
    endfunction : alias_apply

    // Decode the alias offset of a three-address register group
    function automatic alias_op_t alias_decode(input reg_addr_t a, input reg_addr_t base);
        if (a == base)
            alias_decode = OP_WRITE;
        else if (a == base + 6'h01)
            alias_decode = OP_SET;
        else if (a == base + 6'h02)
            alias_decode = OP_CLEAR;
        else
            alias_decode = OP_NONE;
    endfunction : alias_decode

    // Three-stage synchronisers; a change is accepted once stages two and three agree
    logic [`NUM_ASYNC-1:0] sync1_r, sync2_r, sync3_r, filt_r, filt_prev_r;
    wire  [`NUM_ASYNC-1:0] async_in = {dp_in, id_resistor_conversion_complete, vdat_det,
                                       id_float, line_state, utmi_status};
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_ASYNC; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    sync1_r[gi]     <= 1'b0;
                    sync2_r[gi]     <= 1'b0;
                    sync3_r[gi]     <= 1'b0;
                    filt_r[gi]      <= 1'b0;
                    filt_prev_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi]     <= async_in[gi];
                    sync2_r[gi]     <= sync1_r[gi];
                    sync3_r[gi]     <= sync2_r[gi];
                    filt_prev_r[gi] <= filt_r[gi];
                    if (sync2_r[gi] == sync3_r[gi])
                        filt_r[gi] <= sync3_r[gi];
                end
            end
        end
    endgenerate

    // Filtered sources and their edges
    wire [4:0] status_now   = filt_r[4:0];
    wire [4:0] status_rise  = filt_r[4:0] & ~filt_prev_r[4:0];
    wire [4:0] status_fall  = ~filt_r[4:0] & filt_prev_r[4:0];
    wire [1:0] line_now     = filt_r[6:5];
    wire       float_rise   = filt_r[7] & ~filt_prev_r[7];
    wire       float_fall   = ~filt_r[7] & filt_prev_r[7];
    wire       vdat_change  = filt_r[8] ^ filt_prev_r[8];
    wire       rid_rise     = filt_r[9] & ~filt_prev_r[9];
    wire       dp_now       = filt_r[10];

    // Register state
    reg_byte_t latch_r, scratch_r, ctrl_r, irq_en_r;
    reg_byte_t latch_nxt, scratch_nxt, ctrl_nxt, irq_en_nxt, rdata_nxt;
    logic      alt_int_r, alt_int_nxt;

    // Access decode
    wire alias_op_t scratch_op = reg_write ? alias_decode(reg_addr, `ADDR_SCRATCH)
                                           : OP_NONE;
    wire alias_op_t ctrl_op    = reg_write ? alias_decode(reg_addr, `ADDR_ACC_CTRL)
                                           : OP_NONE;
    wire alias_op_t irq_op     = reg_write ? alias_decode(reg_addr, `ADDR_ACC_IRQ_EN)
                                           : OP_NONE;
    wire latch_read = reg_read && (reg_addr == `ADDR_EVENT_LATCH);

    // Unmasked events; host-disconnect only counts in the host role
    wire [4:0] unmasked  = (status_rise & rise_enable) | (status_fall & fall_enable);
    wire [4:0] latch_set = {unmasked[4:1], unmasked[0] & host_role};

    // Set wins over the read-clear so an event in the read cycle survives
    assign latch_nxt   = ((latch_read ? `RESET_BYTE : latch_r) | {3'b000, latch_set})
                         & `LATCH_MASK;
    assign scratch_nxt = alias_apply(scratch_r, reg_wdata, scratch_op);
    assign ctrl_nxt    = alias_apply(ctrl_r, reg_wdata, ctrl_op) & `CTRL_WRITE_MASK;
    assign irq_en_nxt  = alias_apply(irq_en_r, reg_wdata, irq_op)
                         & `IRQ_EN_WRITE_MASK;

    // Carkit interrupt sources gated by their enables
    wire rid_enabled = irq_en_r[`BIT_IRQ_RID] | vendor_rid_irq_enable;
    wire alt_event   = (float_rise & irq_en_r[`BIT_IRQ_FLOAT_BEG])
                     | (float_fall & irq_en_r[`BIT_IRQ_FLOAT_END])
                     | (vdat_change & irq_en_r[`BIT_IRQ_VDAT])
                     | (rid_rise & rid_enabled);
    // A new event in the acknowledge cycle keeps the flag up
    assign alt_int_nxt = alt_event | (alt_int_r & ~alt_int_ack);

    // Read mux; unmapped addresses read zero
    always_comb begin
        unique case (reg_addr)
            `ADDR_EVENT_LATCH:                  rdata_nxt = latch_r;
            `ADDR_LINE_STATE:                   rdata_nxt = {6'h00, line_now};
            `ADDR_SCRATCH, `ADDR_SCRATCH + 6'h01,
            `ADDR_SCRATCH + 6'h02:              rdata_nxt = scratch_r;
            `ADDR_ACC_CTRL, `ADDR_ACC_CTRL + 6'h01,
            `ADDR_ACC_CTRL + 6'h02:             rdata_nxt = ctrl_r;
            `ADDR_ACC_IRQ_EN, `ADDR_ACC_IRQ_EN + 6'h01,
            `ADDR_ACC_IRQ_EN + 6'h02:           rdata_nxt = irq_en_r;
            default:                            rdata_nxt = `RESET_BYTE;
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            latch_r    <= `RESET_BYTE;
            scratch_r  <= `RESET_BYTE;
            ctrl_r     <= `RESET_BYTE;
            irq_en_r   <= `RESET_BYTE;
            alt_int_r  <= 1'b0;
            reg_rdata  <= `RESET_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            latch_r    <= latch_nxt;
            scratch_r  <= scratch_nxt;
            ctrl_r     <= ctrl_nxt;
            irq_en_r   <= irq_en_nxt;
            alt_int_r  <= alt_int_nxt;
            reg_rvalid <= reg_read;
            if (reg_read)
                reg_rdata <= rdata_nxt;
        end
    end

    // Switch steering from the control byte
    wire tx_en    = ctrl_r[`BIT_TX_ROUTE];
    wire rx_en    = ctrl_r[`BIT_RX_ROUTE];
    wire left_en  = ctrl_r[`BIT_LEFT_AUDIO];
    wire right_en = ctrl_r[`BIT_RIGHT_AUDIO] | ctrl_r[`BIT_MIC];
    wire uart_on  = accessory_mode_select & (tx_en | rx_en);
    // The switch outputs follow the routing bits at once; only dm_oe, data1_oe, data2_oe and the speaker
    // data wait for accessory mode, and the link programs the bits before the mode bit
    assign uart_tx_to_dm       = tx_en;
    assign dm_out              = data0_in;
    assign dm_oe               = accessory_mode_select & tx_en;
    assign uart_rx_from_dp     = rx_en;
    assign data1_out           = rx_en ? dp_now : 1'b1;
    assign data1_oe            = accessory_mode_select;
    assign data2_out           = 1'b0;
    assign data2_oe            = accessory_mode_select & ~ctrl_r[`BIT_DATA2_TRISTATE];
    assign left_speaker_pin    = left_en;
    assign right_speaker_pin   = right_en;
    assign left_speaker_data   = uart_on & left_en & data0_in;
    assign right_speaker_data  = uart_on & right_en & dp_now;
    // Audio switches load the lines, so the comparators would see garbage
    assign se_receiver_disable = left_en | right_en;
    assign id_pin_ground_drive = ctrl_r[`BIT_ID_GND_DRIVE];
    assign alt_int             = alt_int_r;

    // Checks
    sequence s_latch_read;
        reg_read && reg_addr == `ADDR_EVENT_LATCH;
    endsequence
    property p_latch_sets;
        @(posedge clk) disable iff (rst) (|latch_set)
            |=> ((latch_r[4:0] & $past(latch_set)) == $past(latch_set));
    endproperty
    a_latch_sets: assert property (p_latch_sets) else $error("latch bit lost");
    property p_latch_clears;
        @(posedge clk) disable iff (rst) s_latch_read ##0 (latch_set == 5'h00) |=> latch_r == 8'h00;
    endproperty
    a_latch_clears: assert property (p_latch_clears) else $error("latch not cleared");
    property p_hd_host_only;
        @(posedge clk) disable iff (rst) (!host_role && !latch_r[0]) |=> !latch_r[0];
    endproperty
    a_hd_host_only: assert property (p_hd_host_only) else $error("hd latched off host");
    property p_line_read;
        @(posedge clk) disable iff (rst) reg_read && reg_addr == `ADDR_LINE_STATE
            |=> reg_rvalid && reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(line_now);
    endproperty
    a_line_read: assert property (p_line_read) else $error("line state read wrong");
    property p_ctrl_set;
        @(posedge clk) disable iff (rst) reg_write && reg_addr == `ADDR_ACC_CTRL + 6'h01
            |=> ctrl_r == (($past(ctrl_r) | $past(reg_wdata)) & `CTRL_WRITE_MASK);
    endproperty
    a_ctrl_set: assert property (p_ctrl_set) else $error("control set alias wrong");
    property p_irq_clear;
        @(posedge clk) disable iff (rst) reg_write && reg_addr == `ADDR_ACC_IRQ_EN + 6'h02
            |=> irq_en_r == ($past(irq_en_r) & ~$past(reg_wdata)) && irq_en_r[4:3] == 2'b00;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq enable clear wrong");
    property p_data1_high;
        @(posedge clk) disable iff (rst) !ctrl_r[`BIT_RX_ROUTE] |-> data1_out;
    endproperty
    a_data1_high: assert property (p_data1_high) else $error("data1 not high");
    property p_se_off;
        @(posedge clk) disable iff (rst) (ctrl_r[6:4] != 3'b000) |-> se_receiver_disable
            && (right_speaker_pin == (ctrl_r[5] | ctrl_r[6]));
    endproperty
    a_se_off: assert property (p_se_off) else $error("receiver or right switch wrong");
    property p_alt_float;
        @(posedge clk) disable iff (rst) float_rise && irq_en_r[0] |=> alt_int;
    endproperty
    a_alt_float: assert property (p_alt_float) else $error("float interrupt missed");
    // Alias arithmetic, fixed bits, switch routing and interrupt holding
    property p_scratch_write;
        @(posedge clk) disable iff (rst) reg_write && reg_addr == `ADDR_SCRATCH
            |=> scratch_r == $past(reg_wdata);
    endproperty
    a_scratch_write: assert property (p_scratch_write) else $error("scratch write lost");
    property p_scratch_clear;
        @(posedge clk) disable iff (rst) reg_write && reg_addr == `ADDR_SCRATCH + 6'h02
            |=> scratch_r == ($past(scratch_r) & ~$past(reg_wdata));
    endproperty
    a_scratch_clear: assert property (p_scratch_clear) else $error("scratch clear wrong");
    property p_ctrl_write;
        @(posedge clk) disable iff (rst) reg_write && reg_addr == `ADDR_ACC_CTRL
            |=> ctrl_r == ($past(reg_wdata) & `CTRL_WRITE_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");
    property p_irq_set;
        @(posedge clk) disable iff (rst) reg_write && reg_addr == `ADDR_ACC_IRQ_EN + 6'h01
            |=> irq_en_r == (($past(irq_en_r) | $past(reg_wdata)) & `IRQ_EN_WRITE_MASK);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq enable set wrong");
    property p_irq_unimpl;
        @(posedge clk) disable iff (rst) irq_en_r[4:3] == 2'b00;
    endproperty
    a_irq_unimpl: assert property (p_irq_unimpl) else $error("unimplemented enable set");
    property p_latch_ro;
        @(posedge clk) disable iff (rst) reg_write && !reg_read && latch_set == 5'h00
            |=> latch_r == $past(latch_r);
    endproperty
    a_latch_ro: assert property (p_latch_ro) else $error("latch changed by a write");
    property p_tx_route;
        @(posedge clk) disable iff (rst) accessory_mode_select && ctrl_r[`BIT_TX_ROUTE]
            |-> dm_oe && uart_tx_to_dm && dm_out == data0_in;
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("transmit route wrong");
    property p_rx_route;
        @(posedge clk) disable iff (rst) ctrl_r[`BIT_RX_ROUTE]
            |-> uart_rx_from_dp && data1_out == dp_now;
    endproperty
    a_rx_route: assert property (p_rx_route) else $error("receive route wrong");
    property p_data2_release;
        @(posedge clk) disable iff (rst) accessory_mode_select && ctrl_r[`BIT_DATA2_TRISTATE]
            |-> !data2_oe;
    endproperty
    a_data2_release: assert property (p_data2_release) else $error("data2 still driven");
    property p_uart_left;
        @(posedge clk) disable iff (rst) uart_on && left_en |-> left_speaker_data == data0_in;
    endproperty
    a_uart_left: assert property (p_uart_left) else $error("left speaker data wrong");
    // Conversion done only counts while either enable copy is set
    sequence s_rid_armed;
        rid_rise && rid_enabled;
    endsequence
    property p_alt_rid;
        @(posedge clk) disable iff (rst) s_rid_armed |=> alt_int;
    endproperty
    a_alt_rid: assert property (p_alt_rid) else $error("conversion interrupt missed");
    property p_alt_vdat;
        @(posedge clk) disable iff (rst) vdat_change && irq_en_r[`BIT_IRQ_VDAT] |=> alt_int;
    endproperty
    a_alt_vdat: assert property (p_alt_vdat) else $error("detect interrupt missed");
    property p_alt_hold;
        @(posedge clk) disable iff (rst) alt_int && !alt_int_ack |=> alt_int;
    endproperty
    a_alt_hold: assert property (p_alt_hold) else $error("interrupt dropped early");
endmodule : ulpi_phy_latch_carkit_regs

// File: link_partner.sv
// Link controller model: acknowledges alt_int and sends UART transmit bits.
// Assumes the bench sets the acknowledge delay and the UART run flag.
`timescale 1ns/10ps
module link_partner (
    input  wire logic       clk,         // ULPI clock
    input  wire logic       rst,         // Sync reset, active high
    input  wire logic       alt_int,     // Pending alt interrupt
    input  wire logic [7:0] ack_delay,   // Cycles before the acknowledge
    input  wire logic       uart_run,    // Send UART bits while high
    output logic            alt_int_ack, // One-cycle acknowledge
    output logic            data0_in     // UART transmit line
);
    // Bit period 40 ns, offset so no bit change meets a clock edge; idles high
    initial begin
        alt_int_ack = 1'b0;
        data0_in = 1'b1;
        #2;
        forever begin
            #40;
            data0_in = uart_run ? ~data0_in : 1'b1;
        end
    end
    // Acknowledge as an RXCMD would go out, slowly enough for the bench to see it
    always begin
        @(posedge clk);
        if (!rst && alt_int === 1'b1) begin
            repeat (ack_delay) @(posedge clk);
            alt_int_ack <= 1'b1;
            @(posedge clk);
            alt_int_ack <= 1'b0;
            @(posedge clk);
        end
    end
endmodule : link_partner

// File: test_ulpi_phy_latch_carkit_regs.sv
// Self-checking bench for the latch, debug, scratch and accessory registers.
// Assumes the design and link_partner are compiled first; one clock domain.
`timescale 1ns/10ps
module test_ulpi_phy_latch_carkit_regs;
    import accessory_regs_pkg::*;
    // Design pins, bench state and tables
    logic        clk, rst, reg_write, reg_read, reg_rvalid, host_role, uart_run;
    logic        accessory_mode_select, vendor_rid_irq_enable, id_float, vdat_det;
    logic        id_resistor_conversion_complete, dp_in, data0_in, alt_int, alt_int_ack;
    logic        data1_out, data1_oe, data2_out, data2_oe, dm_out, dm_oe, uart_tx_to_dm;
    logic        uart_rx_from_dp, left_speaker_pin, right_speaker_pin, left_speaker_data;
    logic        right_speaker_data, se_receiver_disable, id_pin_ground_drive;
    reg_addr_t   reg_addr;
    reg_byte_t   reg_wdata, reg_rdata, rd_v, e, d;
    logic [4:0]  rise_enable, fall_enable, utmi_status;
    logic [1:0]  line_state;
    logic [7:0]  ack_delay;
    logic [31:0] seed = 32'h000149fd;
    int          err_total = 0, tests_run = 0, op, b;
    reg_addr_t   ra[6] = '{6'h14, 6'h15, 6'h16, 6'h19, 6'h1d, 6'h1c};
    reg_addr_t   base[3] = '{6'h16, 6'h19, 6'h1d};
    reg_byte_t   msk[3] = '{8'hff, 8'hfe, 8'h67};
    reg_byte_t   en_tab[6] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h20, 8'h00};

    ulpi_phy_latch_carkit_regs u_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rvalid, .reg_rdata, .rise_enable, .fall_enable, .host_role,
        .accessory_mode_select, .vendor_rid_irq_enable, .utmi_status, .line_state,
        .id_float, .vdat_det, .id_resistor_conversion_complete, .dp_in, .data0_in,
        .data1_out, .data1_oe, .data2_out, .data2_oe, .dm_out, .dm_oe, .uart_tx_to_dm,
        .uart_rx_from_dp, .left_speaker_pin, .right_speaker_pin, .left_speaker_data,
        .right_speaker_data, .se_receiver_disable, .id_pin_ground_drive, .alt_int,
        .alt_int_ack);
    link_partner u_link (.clk, .rst, .alt_int, .ack_delay, .uart_run, .alt_int_ack,
        .data0_in);

    // Clock and watchdog; the run needs well under a tenth of the watchdog span
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        conclude();
    end
    // Repeatable xorshift source and the alias arithmetic of write, set and clear
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic reg_byte_t apply(reg_byte_t old, int o, reg_byte_t v, reg_byte_t m);
        if (o == 0) return v & m;
        if (o == 1) return (old | v) & m;
        return old & ~v & m;
    endfunction : apply
    // Compare, bus cycles driven at the falling edge, and the verdict
    task automatic chk(input reg_byte_t seen, input reg_byte_t exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input reg_addr_t a, input reg_byte_t v);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_write} = {a, v, 1'b1};
        @(negedge clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input reg_addr_t a);
        @(negedge clk);
        {reg_addr, reg_read} = {a, 1'b1};
        @(negedge clk);
        reg_read = 1'b0;
        chk({7'h00, reg_rvalid}, 8'h01);
        rd_v = reg_rdata;
    endtask : rd
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    initial begin
        {reg_write, reg_read, host_role, uart_run, accessory_mode_select, dp_in} = '0;
        {vendor_rid_irq_enable, id_float, vdat_det, id_resistor_conversion_complete} = '0;
        {reg_addr, reg_wdata, rise_enable, fall_enable, utmi_status, line_state} = '0;
        {ack_delay, rst} = {8'h0e, 1'b1};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        // Reset values; the unmapped address reads zero
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(rd_v, 8'h00);
        end
        // Random write, set and clear through every alias, read back at any alias
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 14; k++) begin
                {op, d, accessory_mode_select} = {int'(rnd() % 3), reg_byte_t'(rnd()), 1'b0};
                wr(base[r] + reg_addr_t'(op), d);
                // Each byte is still at its reset value before its first write
                e = apply(k == 0 ? 8'h00 : e, op, d, msk[r]);
                rd(base[r] + reg_addr_t'(rnd() % 3));
                chk(rd_v, e);
                if (r == 1) begin
                    accessory_mode_select = 1'(rnd());
                    #1;
                    d = {id_pin_ground_drive, uart_tx_to_dm, uart_rx_from_dp, left_speaker_pin,
                         right_speaker_pin, se_receiver_disable, dm_oe, data2_oe};
                    rd_v = {e[1], e[2], e[3], e[4], e[5] | e[6], |e[6:4],
                            accessory_mode_select & e[2], accessory_mode_select & ~e[7]};
                    chk(d, rd_v);
                    if (!e[3]) chk({7'h00, data1_out}, 8'h01);
                end
            end
        end
        // Live line state; writes to the read-only bytes are ignored
        wr(6'h15, 8'hff);
        wr(6'h14, 8'hff);
        for (int k = 0; k < 4; k++) begin
            line_state = 2'(rnd());
            repeat (8) @(negedge clk);
            rd(6'h15);
            chk(rd_v, {6'h00, line_state});
        end
        // Latched events under random edge masks, each cleared by its own read
        host_role = 1'b1;
        for (int k = 0; k < 16; k++) begin
            {b, rise_enable, fall_enable} = {k % 5, 5'(rnd()), 5'(rnd())};
            if (k == 15) {b, host_role, rise_enable, fall_enable} = {32'h0, 1'b0, 10'h3ff};
            utmi_status[b] = ~utmi_status[b];
            repeat (10) @(negedge clk);
            rd(6'h14);
            e = {7'h00, utmi_status[b] ? rise_enable[b] : fall_enable[b]};
            e = (b == 0 && !host_role) ? 8'h00 : e << b;
            chk(rd_v, e);
            rd(6'h14);
            chk(rd_v, 8'h00);
        end
        // Alternate interrupt sources, one masked case, each acknowledged by the link
        for (int k = 0; k < 6; k++) begin
            wr(6'h1d, en_tab[k]);
            vendor_rid_irq_enable = (k == 3);
            if (k < 2) id_float = ~id_float;
            else if (k == 3 || k == 4) id_resistor_conversion_complete = 1'b1;
            else vdat_det = ~vdat_det;
            repeat (10) @(negedge clk);
            chk({7'h00, alt_int}, {7'h00, k != 5});
            repeat (20) @(negedge clk);
            chk({7'h00, alt_int}, 8'h00);
            id_resistor_conversion_complete = 1'b0;
            repeat (6) @(negedge clk);
        end
        // UART traffic: routing first, then accessory mode, then data both ways
        wr(6'h19, 8'h1c);
        {accessory_mode_select, uart_run} = 2'b11;
        repeat (40) begin
            @(negedge clk);
            chk({6'h00, dm_out, left_speaker_data}, {6'h00, data0_in, data0_in});
            chk({6'h00, data1_oe, data2_out}, {6'h00, accessory_mode_select, 1'b0});
        end
        uart_run = 1'b0;
        wr(6'h19, 8'h2c);
        for (int k = 0; k < 6; k++) begin
            dp_in = 1'(rnd());
            repeat (10) @(negedge clk);
            chk({6'h00, data1_out, right_speaker_data}, {6'h00, dp_in, dp_in});
        end
        conclude();
    end
endmodule : test_ulpi_phy_latch_carkit_regs
